// >>> common/rqf_defs.vh
// constants for the requester request framer (host side)
// assumes a 32-bit APB register bus and byte addresses on paddr[7:0]
`ifndef RQF_DEFS_VH
`define RQF_DEFS_VH
// register byte offsets
`define RQF_OFS_CTRL      8'h00
`define RQF_OFS_SHAPE     8'h04
`define RQF_OFS_STATUS    8'h08
`define RQF_OFS_DATA      8'h40
// ctrl fields
`define RQF_CTRL_GO       0
`define RQF_CTRL_ALIGNED  1
`define RQF_CTRL_PARITY   2
`define RQF_CTRL_ABORT    3
`define RQF_CTRL_RST      4'h0
// shape fields
`define RQF_SH_LEN        7:0
`define RQF_SH_FBE        11:8
`define RQF_SH_LBE        15:12
`define RQF_SH_AOFS       18:16
`define RQF_SH_SEQ        23:20
`define RQF_SH_ABEAT      27:24
`define RQF_SHAPE_RST     32'h0000_0000
// sideband layout
`define RQF_SB_W          60
`define RQF_SB_FBE        3:0
`define RQF_SB_LBE        7:4
`define RQF_SB_AOFS       10:8
`define RQF_SB_DISC       11
`define RQF_SB_SEQ        27:24
`define RQF_SB_PAR        59:28
// state codes
`define RQF_ST_IDLE       1'b0
`define RQF_ST_SEND       1'b1
`endif

// >>> logic/rqf_host.v
// requester request framer: user-side logic that pushes request packets into the core
// assumes the core stream port shares clk; software loads dwords and shape over APB
`timescale 1ns/1ps
`default_nettype none
`include "rqf_defs.vh"
//////////////////////////////////////////////////////////////////////////////
module rqf_host
#(
   parameter DW                        = 256,
   parameter DEPTH                     = 16,
   parameter user_tag_management_param = 0
)
(
   // clock and reset
   input  wire                clk,
   input  wire                rst,
   // apb slave
   input  wire [7:0]          paddr,
   input  wire                psel,
   input  wire                penable,
   input  wire                pwrite,
   input  wire [31:0]         pwdata,
   output reg  [31:0]         prdata,
   output reg                 pready,
   output reg                 pslverr,
   // request stream toward the core
   output reg  [DW-1:0]       req_in_payload_bus,
   output reg  [`RQF_SB_W-1:0] req_in_sideband_bus,
   output reg                 req_in_end_of_packet,
   output reg  [DW/32-1:0]    req_in_dword_keep,
   output reg                 req_in_present,
   input  wire [3:0]          req_in_accept,
   // progress and tag reports from the core
   input  wire [3:0]          req_progress_number,
   input  wire                req_progress_number_strobe,
   input  wire [5:0]          allocated_np_tag,
   input  wire                allocated_np_tag_strobe
);

   localparam L = DW / 32;
   localparam [8:0] L9 = L;
   // binary state codes
   localparam ST_IDLE = 1'b0;
   localparam ST_SEND = 1'b1;

   //////////////////////////////////////////////////////////////////////////////
   // registers
   reg  [31:0] mem_q [0:DEPTH-1];
   reg  [3:0]  ctrl_q;
   reg  [31:0] shape_q;
   reg         go_q;
   reg         state_q;
   reg  [7:0]  beat_q;
   reg  [3:0]  prog_num_q;
   reg  [7:0]  prog_cnt_q;
   reg  [5:0]  tag_q;
   reg  [7:0]  tag_cnt_q;
   // next values
   reg  [31:0] rdata_d;
   reg         err_d;
   reg  [3:0]  prog_num_d;
   reg  [7:0]  prog_cnt_d;
   reg  [5:0]  tag_d;
   reg  [7:0]  tag_cnt_d;
   wire        access;
   wire        in_data;
   wire [7:0]  len;
   wire        take;
   wire [7:0]  nb;
   wire [8:0]  beat_end;
   wire        last_n;
   wire [DW-1:0] data_n;
   wire [L-1:0]  keep_n;
   wire [31:0]   par_n;
   integer       i;

   assign access   = psel & penable & ~pready;
   assign in_data  = (paddr[7:6] == 2'b01) && (paddr[5:2] < DEPTH);
   assign len      = shape_q[`RQF_SH_LEN];
   // any accept bit will do; all four carry the same value
   assign take     = req_in_present & req_in_accept[0];
   assign nb       = (state_q == ST_IDLE) ? 8'h00 : beat_q + 8'h01;
   assign beat_end = {1'b0, nb} * L9 + L9;
   assign last_n   = (beat_end >= {1'b0, len}) |
                     (ctrl_q[`RQF_CTRL_ABORT] & (nb[3:0] == shape_q[`RQF_SH_ABEAT]));

   //////////////////////////////////////////////////////////////////////////////
   // per-lane dword selection and keep
   genvar j;
   generate
      // lanes past len are zeroed so unkept dwords carry no stale data
      for (j = 0; j < L; j = j + 1)
      begin : g_lane
         localparam [8:0] J9 = j;
         wire [8:0] idx = {1'b0, nb} * L9 + J9;
         assign keep_n[j] = idx < {1'b0, len};
         assign data_n[j*32 +: 32] = keep_n[j] ? mem_q[idx[3:0]] : 32'h0000_0000;
      end
      for (j = 0; j < 32; j = j + 1)
      begin : g_par
         if (j < DW / 8)
         begin : g_used
            assign par_n[j] = ~^data_n[j*8 +: 8];
         end
         else
         begin : g_zero
            assign par_n[j] = 1'b0;
         end
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, answer in the second access cycle
   always @(posedge clk)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         ctrl_q  <= `RQF_CTRL_RST;
         shape_q <= `RQF_SHAPE_RST;
         go_q    <= 1'b0;
      end
      else
      begin
         pready  <= access;
         pslverr <= 1'b0;
         go_q    <= 1'b0;
         if (access)
         begin
            prdata  <= rdata_d;
            pslverr <= err_d;
            // go while a packet is in flight is dropped by the sequencer
            if (pwrite && paddr == `RQF_OFS_CTRL)
            begin
               ctrl_q <= {pwdata[3:1], 1'b0};
               go_q   <= pwdata[`RQF_CTRL_GO];
            end
            if (pwrite && paddr == `RQF_OFS_SHAPE)
            begin
               shape_q <= pwdata;
            end
         end
      end
   end

   // read-back and decode; unmapped offsets read as zero and answer with an error
   always @*
   begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      if (paddr == `RQF_OFS_CTRL)
      begin
         rdata_d = {28'h0000000, ctrl_q[3:1], 1'b0};
      end
      else if (paddr == `RQF_OFS_SHAPE)
      begin
         rdata_d = shape_q;
      end
      else if (paddr == `RQF_OFS_STATUS)
      begin
         rdata_d = {tag_cnt_q, 2'b00, tag_q, prog_cnt_q, prog_num_q, 3'b000, state_q};
      end
      else if (in_data)
      begin
         rdata_d = mem_q[paddr[5:2]];
      end
      else
      begin
         err_d = 1'b1;
      end
   end

   // dword store; writes during a packet would alter later beats, so software waits for idle
   always @(posedge clk)
   begin
      if (rst)
      begin
         for (i = 0; i < DEPTH; i = i + 1)
            mem_q[i] <= 32'h0000_0000;
      end
      else if (access && pwrite && in_data)
      begin
         mem_q[paddr[5:2]] <= pwdata;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // packet sequencer
   always @(posedge clk)
   begin
      if (rst)
      begin
         state_q              <= ST_IDLE;
         beat_q               <= 8'h00;
         req_in_present       <= 1'b0;
         req_in_payload_bus   <= {DW{1'b0}};
         req_in_dword_keep    <= {L{1'b0}};
         req_in_end_of_packet <= 1'b0;
         req_in_sideband_bus  <= {`RQF_SB_W{1'b0}};
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (go_q && len != 8'h00)
               begin
                  state_q        <= ST_SEND;
                  beat_q         <= nb;
                  req_in_present <= 1'b1;
                  req_in_payload_bus   <= data_n;
                  req_in_dword_keep    <= keep_n;
                  req_in_end_of_packet <= last_n;
                  req_in_sideband_bus  <= {`RQF_SB_W{1'b0}};
                  req_in_sideband_bus[`RQF_SB_FBE] <= shape_q[`RQF_SH_FBE];
                  req_in_sideband_bus[`RQF_SB_LBE] <= shape_q[`RQF_SH_LBE];
                  req_in_sideband_bus[`RQF_SB_AOFS] <= ctrl_q[`RQF_CTRL_ALIGNED] ?
                                                       shape_q[`RQF_SH_AOFS] : 3'b000;
                  req_in_sideband_bus[`RQF_SB_SEQ] <= shape_q[`RQF_SH_SEQ];
                  req_in_sideband_bus[`RQF_SB_DISC] <= ctrl_q[`RQF_CTRL_ABORT] &
                                                      (shape_q[`RQF_SH_ABEAT] == 4'h0);
                  req_in_sideband_bus[`RQF_SB_PAR] <= ctrl_q[`RQF_CTRL_PARITY] ?
                                                      par_n : 32'h0000_0000;
               end
            end
            ST_SEND:
            begin
               // everything stays put until the core takes the beat
               if (take)
               begin
                  if (req_in_end_of_packet)
                  begin
                     state_q        <= ST_IDLE;
                     req_in_present <= 1'b0;
                     req_in_sideband_bus[`RQF_SB_DISC] <= 1'b0;
                  end
                  else
                  begin
                     beat_q               <= nb;
                     req_in_payload_bus   <= data_n;
                     req_in_dword_keep    <= keep_n;
                     req_in_end_of_packet <= last_n;
                     // abort ends the packet on the beat that carries it
                     req_in_sideband_bus[`RQF_SB_DISC] <= ctrl_q[`RQF_CTRL_ABORT] &
                        (nb[3:0] == shape_q[`RQF_SH_ABEAT]);
                     req_in_sideband_bus[`RQF_SB_PAR] <= ctrl_q[`RQF_CTRL_PARITY] ?
                                                         par_n : 32'h0000_0000;
                  end
               end
            end
            default:
            begin
               state_q        <= ST_IDLE;
               req_in_present <= 1'b0;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // progress and tag capture; the core strobes for one cycle each
   // counts wrap at 256, so software compares them as deltas
   always @*
   begin
      prog_num_d = prog_num_q;
      prog_cnt_d = prog_cnt_q;
      if (req_progress_number_strobe)
      begin
         prog_num_d = req_progress_number;
         prog_cnt_d = prog_cnt_q + 8'h01;
      end
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         prog_num_q <= 4'h0;
         prog_cnt_q <= 8'h00;
      end
      else
      begin
         prog_num_q <= prog_num_d;
         prog_cnt_q <= prog_cnt_d;
      end
   end

   // tags come back in acceptance order, so the count pairs each tag with its request
   always @*
   begin
      tag_d     = tag_q;
      tag_cnt_d = tag_cnt_q;
      if (allocated_np_tag_strobe && user_tag_management_param == 0)
      begin
         tag_d     = allocated_np_tag;
         tag_cnt_d = tag_cnt_q + 8'h01;
      end
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         tag_q     <= 6'h00;
         tag_cnt_q <= 8'h00;
      end
      else
      begin
         tag_q     <= tag_d;
         tag_cnt_q <= tag_cnt_d;
      end
   end

endmodule
`default_nettype wire

// >>> tb/rqf_core_model.sv
// core end of the request stream: paces beats, reports sequence numbers and tags
// assumes the framer drives the stream from registers on clk
`timescale 1ns/1ps
`default_nettype none
module rqf_core_model #(parameter DW = 64)
(
   // clock, reset, pacing
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             stall,
   // stream
   input  wire logic [DW-1:0]    req_in_payload_bus,
   input  wire logic [59:0]      req_in_sideband_bus,
   input  wire logic             req_in_end_of_packet,
   input  wire logic [DW/32-1:0] req_in_dword_keep,
   input  wire logic             req_in_present,
   output logic      [3:0]       req_in_accept,
   // reports
   output logic      [3:0]       req_progress_number,
   output logic                  req_progress_number_strobe,
   output logic      [5:0]       allocated_np_tag,
   output logic                  allocated_np_tag_strobe,
   // last packet as seen
   output logic      [7:0]       beats,
   output logic      [7:0]       dwords,
   output logic                  stk,
   output logic      [59:0]      sb0,
   output logic      [DW-1:0]    pl0
);
logic [7:0] cyc_q = 8'h00;
logic [2:0] dly_q = 3'h0;
logic [5:0] tag_q = 6'h00;
logic [3:0] seq_q = 4'h0;
logic       fst_q = 1'b1;
wire        take  = req_in_present && req_in_accept[0];
// stall drops accept every other cycle, so holds are exercised mid-packet
assign req_in_accept = {4{!(stall && cyc_q[0])}};
assign req_progress_number = seq_q;
assign req_progress_number_strobe = dly_q == 3'h1;
assign allocated_np_tag = tag_q;
assign allocated_np_tag_strobe = dly_q == 3'h1;
always @(posedge clk)
begin
   cyc_q <= rst ? 8'h00 : cyc_q + 8'h01;
   dly_q <= rst ? 3'h0 : (take && req_in_end_of_packet) ? 3'h3 : dly_q - {2'b00, |dly_q};
   tag_q <= rst ? 6'h00 : tag_q + {5'h00, dly_q == 3'h1};
   if (rst)
      fst_q <= 1'b1;
   else if (take)
   begin
      fst_q  <= req_in_end_of_packet;
      beats  <= fst_q ? 8'h01 : beats + 8'h01;
      dwords <= (fst_q ? 8'h00 : dwords) + 8'($countones(req_in_dword_keep));
      stk    <= (stk && !fst_q) || req_in_sideband_bus[11];
      if (fst_q)
      begin
         sb0   <= req_in_sideband_bus;
         pl0   <= req_in_payload_bus;
         seq_q <= req_in_sideband_bus[27:24];
      end
   end
end
endmodule
`default_nettype wire

// >>> tb/rqf_host_assertions.sv
// port checker for the request framer
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module rqf_host_chk #(parameter DW = 256)
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [DW-1:0]     req_in_payload_bus,
   input wire logic [59:0]       req_in_sideband_bus,
   input wire logic              req_in_end_of_packet,
   input wire logic [DW/32-1:0]  req_in_dword_keep,
   input wire logic              req_in_present,
   input wire logic [3:0]        req_in_accept
);
wire            pr  = req_in_present;
wire            ac  = req_in_accept[0];
wire            eop = req_in_end_of_packet;
wire [59:0]     sb  = req_in_sideband_bus;
wire [DW/32-1:0] kp = req_in_dword_keep;
function automatic [DW/8-1:0] par(input [DW-1:0] d);
   for (int i = 0; i < DW/8; i++)
      par[i] = ~^d[8*i+:8];
endfunction
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
a_hold_stall: assert property (pr && !ac |=> pr && $stable(req_in_payload_bus)
   && $stable(sb) && $stable(kp) && $stable(eop)) else $error("beat changed while stalled");
a_valid_through: assert property (pr && !(ac && eop) |=> pr)
   else $error("present dropped inside packet");
a_gap_after: assert property (pr && ac && eop |=> !pr) else $error("no gap after last");
a_keep_shape: assert property (pr |-> kp[0] && ((kp + 1'b1) & kp) == 0 && (eop || &kp))
   else $error("keep not contiguous");
a_fields_held: assert property (pr && ac && !eop |=> $stable(sb[10:0]) && $stable(sb[27:12]))
   else $error("sideband fields moved");
a_abort_last: assert property (pr && sb[11] |-> eop) else $error("abort beat not last");
a_parity_odd: assert property (pr && |sb[59:28] |-> sb[28+:DW/8] == par(req_in_payload_bus))
   else $error("byte parity wrong");
a_apb_wait: assert property (psel && penable && !pready |=> pready) else $error("apb late");
a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
c_stall: cover property (pr && !ac);
c_abort: cover property (pr && ac && sb[11]);
c_single: cover property (pr && ac && eop && !$past(pr));
endmodule
bind rqf_host rqf_host_chk #(.DW(DW)) chk_u (.clk, .rst, .psel, .penable, .pready, .pslverr,
   .req_in_payload_bus, .req_in_sideband_bus, .req_in_end_of_packet, .req_in_dword_keep,
   .req_in_present, .req_in_accept);
`default_nettype wire

// >>> tb/test_rqf_host.sv
// bench for the request framer against a behavioural core end
// assumes rqf_defs.vh on the include path and the port checker bound
`timescale 1ns/1ps
`default_nettype none
`include "rqf_defs.vh"
module test_rqf_host;
logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0;
logic [7:0]  paddr = 8'h00;
logic [31:0] pwdata = 32'h0, rd;
logic        er;
int          errors = 0, cmp_count = 0, cycles = 0;
wire  [31:0] prdata;
wire         pready, pslverr, req_in_end_of_packet, req_in_present, stk;
wire         req_progress_number_strobe, allocated_np_tag_strobe;
wire  [63:0] req_in_payload_bus, pl0;
wire  [59:0] req_in_sideband_bus, sb0;
wire  [1:0]  req_in_dword_keep;
wire  [3:0]  req_in_accept, req_progress_number;
wire  [5:0]  allocated_np_tag;
wire  [7:0]  beats, dwords;
rqf_host #(.DW(64)) dut_u (.*);
rqf_core_model #(.DW(64)) core_u (.*);
initial forever #5 clk = ~clk;
always @(posedge clk)
begin
   cycles <= cycles + 1;
   if (cycles == 20000)
   begin
      errors = errors + 1;
      end_sim;
   end
end
task chk(input logic [63:0] seen, input logic [63:0] exp);
   cmp_count = cmp_count + 1;
   if (seen !== exp)
   begin
      errors = errors + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
   end
endtask
// request held until pready is seen at a rising edge
task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
   @(posedge clk);
   psel <= 1'b1;
   pwrite <= wr;
   paddr <= a;
   pwdata <= d;
   @(posedge clk);
   penable <= 1'b1;
   do
      @(posedge clk);
   while (pready !== 1'b1);
   rd = prdata;
   er = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
endtask
// status poll waits for the n-th progress report, not for a fixed delay
task send(input logic [3:0] ctrl, input logic [31:0] shape, input logic [7:0] n);
   for (int i = 0; i < shape[7:0]; i++)
      apb(1'b1, `RQF_OFS_DATA + 8'(4 * i), 32'hC0DE_0000 + i);
   apb(1'b1, `RQF_OFS_SHAPE, shape);
   apb(1'b1, `RQF_OFS_CTRL, {28'h0, ctrl});
   do
      apb(1'b0, `RQF_OFS_STATUS, 32'h0);
   while (rd[0] !== 1'b0 || rd[15:8] !== n);
endtask
task t_regs;
   apb(1'b0, `RQF_OFS_SHAPE, 32'h0);
   chk(rd, `RQF_SHAPE_RST);
   apb(1'b0, 8'hFC, 32'h0);
   chk({er, rd}, 33'h1_0000_0000);
   apb(1'b1, `RQF_OFS_DATA + 8'h0C, 32'h5A5A_A5A5);
   apb(1'b0, `RQF_OFS_DATA + 8'h0C, 32'h0);
   chk(rd, 32'h5A5A_A5A5);
   apb(1'b1, `RQF_OFS_CTRL, 32'h1);
   apb(1'b0, `RQF_OFS_STATUS, 32'h0);
   chk(rd, 32'h0);
   $display("t_regs done");
endtask
task t_plain;
   send(4'h1, 32'h0F50_3F03, 8'h01);
   chk(rd & 32'hFF3F_FFF1, 32'h0100_0150);
   chk(beats, 8'h02);
   chk(dwords, 8'h03);
   chk(sb0[27:0], 28'h500_003F);
   chk(pl0, 64'hC0DE_0001_C0DE_0000);
   $display("t_plain done");
endtask
task t_stall;
   stall <= 1'b1;
   send(4'h7, 32'h0FA3_8105, 8'h02);
   stall <= 1'b0;
   chk(rd & 32'hFF3F_FFF1, 32'h0201_02A0);
   chk({beats, dwords}, 16'h0305);
   chk(sb0[27:0], 28'hA00_0381);
   $display("t_stall done");
endtask
task t_abort;
   send(4'h9, 32'h0100_FF06, 8'h03);
   chk(rd & 32'hFF3F_FFF1, 32'h0302_0300);
   chk({beats, dwords, 7'h00, stk}, 24'h0204_01);
   $display("t_abort done");
endtask
task t_single;
   send(4'h1, 32'h0F70_0F01, 8'h04);
   chk(rd & 32'hFF3F_FFF1, 32'h0403_0470);
   chk({beats, dwords}, 16'h0101);
   $display("t_single done");
endtask
task end_sim;
   $display("comparisons %0d mismatches %0d", cmp_count, errors);
   if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
   else
      $display("Testbench failed");
   $finish;
endtask
initial
begin
   repeat (12) @(posedge clk);
   rst <= 1'b0;
   t_regs;
   t_plain;
   t_stall;
   t_abort;
   t_single;
   end_sim;
end
endmodule
`default_nettype wire
